// file: logic/ssdr_pkg.sv
// Constants, register map and carrier types of the serial shift unit.
// Assumes a 100 MHz system clock and an 8-bit register port.
package ssdr_pkg;

  // Register offsets on the 8-bit address port.
  localparam logic [7:0] ADDR_CTRL = 8'hF3;
  localparam logic [7:0] ADDR_STATUS = 8'hF4;
  localparam logic [7:0] ADDR_DATA = 8'hF5;
  localparam logic [7:0] ADDR_IRQEN = 8'hF6;
  localparam logic [7:0] ADDR_MASK = 8'hF7;

  // Status register fields; the mask register uses the same layout.
  localparam int ST_DONE_BIT = 7;
  localparam int ST_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int ST_OVF_BIT = 5;
  localparam int ST_MODE_FAULT_FLAG_BIT = 4;
  localparam int ST_FDD_BIT = 3;
  localparam int ST_TXF_BIT = 2;

  // Control register fields.
  localparam int CTRL_SOE_BIT = 7;
  localparam int CTRL_EN_BIT = 6;
  localparam int CTRL_MODE_BIT = 4;

  // Interrupt enable register fields.
  localparam int IRQ_SERIAL_BIT = 0;
  localparam int IRQ_GLOBAL_BIT = 1;

  // Values after reset.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQEN_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hB0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Serial clock timing in controller mode.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYCLES_INT =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF_CYCLES = SCLK_HALF_CYCLES_INT[3:0];
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CTRL = 2'b01,
    ST_PERI = 2'b10
  } ssdr_state_t;

  // One group per direction of the four serial pins.
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic sel;
  } ssdr_pins_t;

  // Register port request from the processor side.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } ssdr_bus_req_t;

endpackage

// file: logic/ssdr_spi_unit.sv
// Serial shift unit: status flags, data register and the byte shifter.
// Assumes a one-cycle register port and serial pins from outside the clock.
//
// Operation
// - Set transfer done on byte completion.
// - Done plus both enables and its mask bit requests interrupt.
// - Done flag cleared only by software.
// - Data writes ignored while done set.
// - Collision sets sticky flag, no interrupt.
// - Overrun sets sticky flag, may interrupt.
// - Select low in controller mode faults.
// - Detect enabled: select is fault input.
// - Detect disabled: select follows output enable.
// - Detect disable matters only in controller mode.
// - Bit 2 shows transmit buffer full.
// - Data write loads the transmit path.
// - Data read returns receive buffer.
// - Controller write starts full-duplex byte exchange.
// - Driven select low per transfer, high idle.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps

module ssdr_spi_unit (
  input wire logic clock,
  input wire logic rst,
  input wire ssdr_pkg::ssdr_bus_req_t busReq,
  output logic [7:0] rdData,
  output logic irq,
  input wire ssdr_pkg::ssdr_pins_t pinIn,
  output ssdr_pkg::ssdr_pins_t pinOut,
  output ssdr_pkg::ssdr_pins_t pinOe_n
);
  import ssdr_pkg::*;

  typedef struct packed {
    ssdr_state_t state;
    logic [7:0] ctrl;
    logic [7:0] irqEn;
    logic [7:0] mask;
    logic done;
    logic write_collision_flag;
    logic ovf;
    logic mode_fault_flag;
    logic fdd;
    logic txFull;
    logic [7:0] txByte;
    logic [7:0] rxBuf;
    logic rxUnread;
    logic [7:0] shifter;
    logic [2:0] bitCnt;
    logic [3:0] divCnt;
    logic sample;
    ssdr_pins_t sync1;
    ssdr_pins_t sync2;
    ssdr_pins_t prev;
    logic [7:0] rdData;
    logic irq;
    ssdr_pins_t pinOut;
    ssdr_pins_t pinOe_n;
  } ssdr_regs_t;

  ssdr_regs_t cur;
  ssdr_regs_t next_;

  function automatic logic [7:0] status_byte(input ssdr_regs_t r);
    status_byte = 8'h00;
    status_byte[ST_DONE_BIT] = r.done;
    status_byte[ST_WRITE_COLLISION_FLAG_BIT] = r.write_collision_flag;
    status_byte[ST_OVF_BIT] = r.ovf;
    status_byte[ST_MODE_FAULT_FLAG_BIT] = r.mode_fault_flag;
    status_byte[ST_FDD_BIT] = r.fdd;
    status_byte[ST_TXF_BIT] = r.txFull;
  endfunction

  always_comb begin
    logic enabled;
    logic ctrlMode;
    logic faultArm;
    logic fault;
    logic rises;
    logic falls;
    logic readData;
    logic evDone;
    logic evCol;
    logic evOvf;
    logic [7:0] rxByte;
    logic ctrlDrive;
    enabled = 1'b0;
    ctrlMode = 1'b0;
    faultArm = 1'b0;
    fault = 1'b0;
    rises = 1'b0;
    falls = 1'b0;
    readData = 1'b0;
    evDone = 1'b0;
    evCol = 1'b0;
    evOvf = 1'b0;
    rxByte = 8'h00;
    ctrlDrive = 1'b0;
    next_ = cur;

    // Two-stage synchronisers and edge history for every pin input.
    next_.sync1 = pinIn;
    next_.sync2 = cur.sync1;
    next_.prev = cur.sync2;
    next_.rdData = 8'h00;

    enabled = cur.ctrl[CTRL_EN_BIT];
    ctrlMode = cur.ctrl[CTRL_MODE_BIT];
    faultArm = enabled & ctrlMode & ~cur.fdd;
    fault = faultArm & ~cur.sync2.sel;
    rises = cur.sync2.sclk & ~cur.prev.sclk;
    falls = ~cur.sync2.sclk & cur.prev.sclk;

    // Register reads answer one cycle later.
    if (busReq.rd) begin
      unique case (busReq.addr)
        ADDR_CTRL: next_.rdData = cur.ctrl;
        ADDR_STATUS: next_.rdData = status_byte(cur);
        ADDR_DATA: begin
          next_.rdData = cur.rxBuf;
          next_.rxUnread = 1'b0;
          readData = 1'b1;
        end
        ADDR_IRQEN: next_.irqEn = cur.irqEn;
        ADDR_MASK: next_.rdData = cur.mask;
        default: next_.rdData = 8'h00;
      endcase
      if (busReq.addr == ADDR_IRQEN) begin
        next_.rdData = cur.irqEn;
      end
    end

    // Register writes; flag clears come first so a same-cycle event wins.
    if (busReq.wr) begin
      unique case (busReq.addr)
        ADDR_CTRL: next_.ctrl = busReq.wrData;
        ADDR_IRQEN: next_.irqEn = busReq.wrData;
        ADDR_MASK: next_.mask = busReq.wrData;
        ADDR_STATUS: begin
          next_.fdd = busReq.wrData[ST_FDD_BIT];
          if (busReq.wrData[ST_DONE_BIT]) begin
            next_.done = 1'b0;
          end
          if (busReq.wrData[ST_WRITE_COLLISION_FLAG_BIT]) begin
            next_.write_collision_flag = 1'b0;
          end
          if (busReq.wrData[ST_OVF_BIT]) begin
            next_.ovf = 1'b0;
          end
          if (busReq.wrData[ST_MODE_FAULT_FLAG_BIT]) begin
            next_.mode_fault_flag = 1'b0;
          end
        end
        ADDR_DATA: begin
          if (cur.done) begin
            next_.txByte = cur.txByte;
          end else if (cur.state != ST_IDLE) begin
            evCol = 1'b1;
          end else begin
            next_.txByte = busReq.wrData;
            next_.txFull = 1'b1;
          end
        end
        default: next_.ctrl = next_.ctrl;
      endcase
    end

    unique case (cur.state)
      ST_IDLE: begin
        next_.bitCnt = 3'h0;
        next_.divCnt = 4'h0;
        if (enabled && ctrlMode && !fault && cur.txFull) begin
          next_.state = ST_CTRL;
          next_.shifter = cur.txByte;
          next_.pinOut.mosi = cur.txByte[7];
          next_.txFull = 1'b0;
        end else if (enabled && !ctrlMode && !cur.sync2.sel) begin
          next_.state = ST_PERI;
          next_.shifter = cur.txFull ? cur.txByte : 8'h00;
          next_.pinOut.miso = cur.txFull ? cur.txByte[7] : 1'b0;
          next_.txFull = 1'b0;
        end
      end
      ST_CTRL: begin
        if (fault || !enabled || !ctrlMode) begin
          next_.state = ST_IDLE;
          next_.pinOut.sclk = 1'b0;
        end else if (cur.divCnt == SCLK_HALF_CYCLES - 4'h1) begin
          next_.divCnt = 4'h0;
          next_.pinOut.sclk = ~cur.pinOut.sclk;
          if (!cur.pinOut.sclk) begin
            next_.sample = cur.sync2.miso;
          end else begin
            next_.shifter = {cur.shifter[6:0], cur.sample};
            next_.pinOut.mosi = cur.shifter[6];
            if (cur.bitCnt == LAST_BIT) begin
              evDone = 1'b1;
              rxByte = {cur.shifter[6:0], cur.sample};
              next_.state = ST_IDLE;
            end else begin
              next_.bitCnt = cur.bitCnt + 3'h1;
            end
          end
        end else begin
          next_.divCnt = cur.divCnt + 4'h1;
        end
      end
      ST_PERI: begin
        if (cur.sync2.sel || !enabled || ctrlMode) begin
          next_.state = ST_IDLE;
        end else if (rises) begin
          next_.shifter = {cur.shifter[6:0], cur.sync2.mosi};
          if (cur.bitCnt == LAST_BIT) begin
            evDone = 1'b1;
            rxByte = {cur.shifter[6:0], cur.sync2.mosi};
            next_.bitCnt = 3'h0;
            next_.shifter = cur.txFull ? cur.txByte : 8'h00;
            next_.pinOut.miso = cur.txFull ? cur.txByte[7] : 1'b0;
            next_.txFull = 1'b0;
          end else begin
            next_.bitCnt = cur.bitCnt + 3'h1;
          end
        end else if (falls && cur.bitCnt != 3'h0) begin
          next_.pinOut.miso = cur.shifter[7];
        end
      end
      default: next_.state = ST_IDLE;
    endcase

    // A finished byte lands in the receive buffer unless one is unread and not read this cycle.
    if (evDone) begin
      if (cur.rxUnread && !readData) begin
        evOvf = 1'b1;
      end else begin
        next_.rxBuf = rxByte;
        next_.rxUnread = 1'b1;
      end
    end

    // Sticky flags; setting overrides a clear in the same cycle.
    next_.done = next_.done | evDone;
    next_.write_collision_flag = next_.write_collision_flag | evCol;
    next_.ovf = next_.ovf | evOvf;
    next_.mode_fault_flag = next_.mode_fault_flag | fault;

    // Pin drive; enables are low while this unit drives the pin.
    ctrlDrive = enabled & ctrlMode & ~fault;
    next_.pinOe_n.sclk = ~ctrlDrive;
    next_.pinOe_n.mosi = ~ctrlDrive;
    next_.pinOe_n.miso = ~(next_.state == ST_PERI);
    if (!ctrlDrive) begin
      next_.pinOut.sclk = 1'b0;
    end
    // Select is driven only when detection is off and output enabled.
    next_.pinOe_n.sel =
      ~(ctrlDrive & cur.fdd & cur.ctrl[CTRL_SOE_BIT]);
    next_.pinOut.sel = ~(next_.state == ST_CTRL);

    // One interrupt line shared by done, overrun and fault.
    next_.irq = cur.irqEn[IRQ_SERIAL_BIT] & cur.irqEn[IRQ_GLOBAL_BIT] &
      ((next_.done & cur.mask[ST_DONE_BIT]) |
       (next_.ovf & cur.mask[ST_OVF_BIT]) |
       (next_.mode_fault_flag & cur.mask[ST_MODE_FAULT_FLAG_BIT]));
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.ctrl <= CTRL_RESET;
      cur.irqEn <= IRQEN_RESET;
      cur.mask <= MASK_RESET;
      cur.rxBuf <= DATA_RESET;
      cur.txByte <= DATA_RESET;
      cur.sync1 <= 4'h1;
      cur.sync2 <= 4'h1;
      cur.prev <= 4'h1;
      cur.pinOut <= 4'h1;
      cur.pinOe_n <= 4'hF;
    end else begin
      cur <= next_;
    end
  end

  assign rdData = cur.rdData;
  assign irq = cur.irq;
  assign pinOut = cur.pinOut;
  assign pinOe_n = cur.pinOe_n;

endmodule

// file: test/ssdr_spi_checker.sv
// Port assertions for the serial shift unit.
// Assumes the bench keeps the read strobe low during reset.
`timescale 1ns/1ps
module ssdr_spi_checker (
  input wire logic clock,
  input wire logic rst,
  input wire ssdr_pkg::ssdr_bus_req_t busReq,
  input wire logic [7:0] rdData,
  input wire logic irq,
  input wire ssdr_pkg::ssdr_pins_t pinIn,
  input wire ssdr_pkg::ssdr_pins_t pinOut,
  input wire ssdr_pkg::ssdr_pins_t pinOe_n
);
  import ssdr_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic ctlOn;
  logic fddSeen;
  assign ctlOn = !pinOe_n.sclk;
  // Mirrors the detect-disable bit, which is not visible on the ports.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fddSeen <= 1'b0;
    end else if (busReq.wr && busReq.addr == ADDR_STATUS) begin
      fddSeen <= busReq.wrData[ST_FDD_BIT];
    end
  end
  sequence s_selLow3;
    (ctlOn && !fddSeen && pinOe_n.sel && !pinIn.sel) [*3];
  endsequence
  sequence s_highHalf;
    pinOut.sclk [*3] ##1 !pinOut.sclk;
  endsequence
  a_rd_idle_zero: assert property (
    !$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data not zero outside a read");
  a_sclk_half: assert property (
    $rose(pinOut.sclk) && ctlOn |=> s_highHalf)
    else $error("serial clock high phase not four cycles");
  a_mosi_on_low: assert property (
    $changed(pinOut.mosi) && !pinOe_n.mosi |-> !pinOut.sclk)
    else $error("data out changed while serial clock high");
  a_sel_in_xfer: assert property (
    $rose(pinOut.sclk) && !pinOe_n.sel |-> !pinOut.sel)
    else $error("select not low during a clock pulse");
  a_sel_needs_ctl: assert property (
    !pinOe_n.sel |-> ctlOn)
    else $error("select driven outside controller mode");
  a_one_data_out: assert property (
    !pinOe_n.miso |-> pinOe_n.mosi && pinOe_n.sclk)
    else $error("both link roles driven at once");
  a_fault_release: assert property (
    s_selLow3 |-> ##[1:3] pinOe_n.sclk)
    else $error("low select did not stop the controller");
  a_irq_fall_wr: assert property (
    $fell(irq) |-> $past(busReq.wr) || $past(busReq.wr, 2))
    else $error("interrupt dropped without a write");
endmodule
bind ssdr_spi_unit ssdr_spi_checker i_chk (
  .clock(clock), .rst(rst), .busReq(busReq), .rdData(rdData),
  .irq(irq), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n));

// file: test/ssdr_spi_peer.sv
// Behavioural serial device on the far side of the controller link.
// Assumes clock idle low, sample on rising, shift on falling, MSB first.
`timescale 1ns/1ps
module ssdr_spi_peer (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selN,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] sh = 8'h00;
  initial rxByte = 8'h00;
  initial miso = 1'b0;
  always @(negedge selN) sh = txByte;
  always @(posedge sclk) if (!selN) rxByte = {rxByte[6:0], mosi};
  always @(negedge sclk) if (!selN) sh = {sh[6:0], 1'b0};
  // Once released the line shows the inverse of its last level.
  always @(selN, sh) begin
    if (!selN) miso = sh[7];
    else miso = ~miso;
  end
endmodule

// file: test/test_ssdr_spi_unit.sv
// Self-checking bench of the serial shift unit with a serial peer.
// Assumes the register map and flag layout of the unit's package.
`timescale 1ns/1ps
module test_ssdr_spi_unit;
  import ssdr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  ssdr_bus_req_t busReq = '0;
  logic [7:0] rdData;
  logic irq;
  ssdr_pins_t pinIn;
  ssdr_pins_t pinOut;
  ssdr_pins_t pinOe_n;
  logic benchSel = 1'b1;
  logic benchSclk = 1'b0;
  logic benchMosi = 1'b0;
  logic peerMiso;
  logic [7:0] peerTx = 8'h00;
  logic [7:0] peerRx;
  logic [31:0] seed = 32'h0000_26fe;
  logic [7:0] expSt = 8'h00;
  logic [7:0] expRx = 8'h00;
  logic unread = 1'b0;
  int miscompares = 0;
  int samplesChecked = 0;
  int n;
  always #5 clock = ~clock;
  assign pinIn.sclk = pinOe_n.sclk ? benchSclk : pinOut.sclk;
  assign pinIn.mosi = pinOe_n.mosi ? benchMosi : pinOut.mosi;
  assign pinIn.miso = pinOe_n.miso ? peerMiso : pinOut.miso;
  assign pinIn.sel = pinOe_n.sel ? benchSel : pinOut.sel;
  ssdr_spi_unit i_dut (.clock(clock), .rst(rst), .busReq(busReq),
    .rdData(rdData), .irq(irq), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe_n(pinOe_n));
  ssdr_spi_peer i_peer (.sclk(pinIn.sclk), .mosi(pinIn.mosi),
    .selN(pinIn.sel), .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq.addr <= a;
    busReq.wrData <= d;
    busReq.wr <= 1'b1;
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1 chk(rdData, e);
    if (a == ADDR_DATA) unread = 1'b0;
  endtask
  task automatic irqIs(input logic e);
    @(posedge clock);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic clr(input logic [7:0] d);
    wr(ADDR_STATUS, d);
    expSt = (expSt & ~(d & 8'hF0) & 8'hF7) | (d & 8'h08);
  endtask
  task automatic fin(input logic [7:0] d, input logic [7:0] p);
    for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge clock);
    irqIs(1'b1);
    chk(peerRx, d);
    if (unread) expSt |= 8'h20;
    else expRx = p;
    unread = 1'b1;
    expSt |= 8'h80;
  endtask
  task automatic xfer(input logic [7:0] d, input logic [7:0] p);
    peerTx <= p;
    wr(ADDR_DATA, d);
    fin(d, p);
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    logic [7:0] d;
    logic [7:0] p;
    logic [7:0] q;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_DATA, DATA_RESET);
    rd(ADDR_IRQEN, IRQEN_RESET);
    rd(ADDR_MASK, MASK_RESET);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    d = rnd();
    p = rnd();
    wr(ADDR_DATA, d);
    rd(ADDR_STATUS, 8'h04);
    rd(ADDR_DATA, 8'h00);
    wr(ADDR_IRQEN, 8'h03);
    clr(8'h08);
    peerTx <= p;
    wr(ADDR_CTRL, 8'hD0);
    repeat (20) @(posedge clock);
    wr(ADDR_DATA, rnd());
    expSt |= 8'h40;
    fin(d, p);
    rd(ADDR_STATUS, expSt);
    repeat (30) @(posedge clock);
    irqIs(1'b1);
    wr(ADDR_DATA, rnd());
    rd(ADDR_STATUS, expSt);
    rd(ADDR_DATA, expRx);
    wr(ADDR_MASK, 8'h00);
    irqIs(1'b0);
    wr(ADDR_MASK, MASK_RESET);
    wr(ADDR_IRQEN, 8'h01);
    irqIs(1'b0);
    wr(ADDR_IRQEN, 8'h03);
    irqIs(1'b1);
    clr(8'h88);
    irqIs(1'b0);
    clr(8'h48);
    rd(ADDR_STATUS, expSt);
    for (int i = 0; i < 2; i++) begin
      xfer(rnd(), rnd());
      clr(8'h88);
    end
    rd(ADDR_STATUS, expSt);
    irqIs(1'b1);
    rd(ADDR_DATA, expRx);
    clr(8'hF0);
    @(posedge clock) benchSel <= 1'b0;
    repeat (8) @(posedge clock);
    expSt |= 8'h10;
    rd(ADDR_STATUS, expSt);
    irqIs(1'b1);
    @(posedge clock) benchSel <= 1'b1;
    // Let the high select pass the synchroniser before clearing the fault.
    repeat (2) @(posedge clock);
    clr(8'h10);
    wr(ADDR_CTRL, 8'h40);
    d = rnd();
    p = rnd();
    wr(ADDR_DATA, p);
    @(posedge clock) benchSel <= 1'b0;
    repeat (8) @(posedge clock);
    rd(ADDR_STATUS, expSt);
    // Peripheral byte: bench is the link master, 80 ns clock, mode 0.
    q = 8'h00;
    @(posedge clock);
    for (int i = 7; i >= 0; i--) begin
      benchMosi <= d[i];
      repeat (4) @(posedge clock);
      benchSclk <= 1'b1;
      q = {q[6:0], pinIn.miso};
      repeat (4) @(posedge clock);
      benchSclk <= 1'b0;
    end
    chk(q, p);
    expSt |= 8'h80;
    rd(ADDR_STATUS, expSt);
    rd(ADDR_DATA, d);
    irqIs(1'b1);
    @(posedge clock) benchSel <= 1'b1;
    print_verdict();
  end
endmodule
